// file: hdl/bsi_pkg.sv
// Shared constants and types for the boundary-scan instruction logic
package bsi_pkg;

	localparam int         IR_W       = 3;
	localparam int         ID_W       = 32;
	localparam logic [2:0] IR_EXTEST  = 3'h0;
	localparam logic [2:0] IR_IDCODE  = 3'h1;
	localparam logic [2:0] IR_SAMPLEZ = 3'h2;
	localparam logic [2:0] IR_SAMPLE  = 3'h4;
	localparam logic [2:0] IR_BYPASS  = 3'h7;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	localparam logic [2:0] IR_RESET   = IR_IDCODE;
	localparam logic [1:0] SYNC_RESET = 2'h0;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} bsi_tap_pins_t;

	typedef enum logic [15:0] {
		S_TLR   = 16'h0001,
		S_RTI   = 16'h0002,
		S_SELDR = 16'h0004,
		S_CAPDR = 16'h0008,
		S_SHDR  = 16'h0010,
		S_EX1DR = 16'h0020,
		S_PADR  = 16'h0040,
		S_EX2DR = 16'h0080,
		S_UPDR  = 16'h0100,
		S_SELIR = 16'h0200,
		S_CAPIR = 16'h0400,
		S_SHIR  = 16'h0800,
		S_EX1IR = 16'h1000,
		S_PAIR  = 16'h2000,
		S_EX2IR = 16'h4000,
		S_UPIR  = 16'h8000
	} bsi_tap_state_t;

	typedef enum logic [2:0] {
		PATH_BYP = 3'h1,
		PATH_ID  = 3'h2,
		PATH_BSR = 3'h4
	} bsi_path_t;

endpackage

// file: hdl/bsi_sync.sv
// Two-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/1ps
module bsi_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	if (W < 1) begin : g_check
		$error("bsi_sync: width must be at least one");
	end

	logic [W-1:0] meta_reg;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= '0;
			q        <= '0;
		end else if (ce) begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// file: hdl/bsi_scan.sv
// Boundary-scan test port: TAP sequencing, instruction decode and scan registers
`timescale 1ns/1ps
module bsi_scan
	import bsi_pkg::*;
#(
	parameter int          IN_W     = 73,
	parameter int          Q_W      = 36,
	parameter logic [31:0] ID_VALUE = 32'h0000_0001  // Arbitrary value
) (
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	input  wire bsi_tap_pins_t     tapPins,
	input  wire logic              tmsDriven,
	input  wire logic              tdiDriven,
	input  wire logic [IN_W-1:0]   memIn,
	input  wire logic [Q_W-1:0]    qPadIn,
	input  wire logic [Q_W-1:0]    coreQ,
	input  wire logic              coreQOe,
	output logic      [Q_W-1:0]    qOut,
	output logic                   qOe,
	output logic                   tdo,
	output logic                   tdoOe
);
	localparam int BSR_W  = IN_W + Q_W;
	localparam int SYNC_W = 3 + BSR_W;

	if (IN_W < 1 || Q_W < 1 || ID_VALUE[0] != 1'b1) begin : g_check
		$error("bsi_scan: bad widths or identification value");
	end

	bsi_tap_pins_t   pinsRaw;
	bsi_tap_pins_t   pinsSync;
	logic [IN_W-1:0] memInSync;
	logic [Q_W-1:0]  qPadSync;
	logic            tckPrev_reg;
	logic            tckRise;
	logic            tckFall;
	bsi_tap_state_t  tapState_reg;
	bsi_tap_state_t  tapState_next;
	logic [IR_W-1:0] irShift_reg;
	logic [IR_W-1:0] ir_reg;
	logic [ID_W-1:0] idShift_reg;
	logic            bypass_reg;
	logic [BSR_W-1:0] bsrShift_reg;
	logic [BSR_W-1:0] bsrUpd_reg;
	bsi_path_t       path;

	// Floating TMS/TDI behave as tied high
	always_comb begin
		pinsRaw.tck = tapPins.tck;
		pinsRaw.tms = tmsDriven ? tapPins.tms : 1'b1;
		pinsRaw.tdi = tdiDriven ? tapPins.tdi : 1'b1;
	end

	// Memory pins change on their own clock; capture is only repeatable if held still
	bsi_sync #(.W(SYNC_W)) u_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.ce      (ce),
		.d       ({pinsRaw, memIn, qPadIn}),
		.q       ({pinsSync, memInSync, qPadSync})
	);

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			tckPrev_reg <= 1'b0;
		end else if (ce) begin
			tckPrev_reg <= pinsSync.tck;
		end
	end
	assign tckRise = pinsSync.tck & ~tckPrev_reg;
	assign tckFall = ~pinsSync.tck & tckPrev_reg;

	function automatic bsi_tap_state_t tapNext(bsi_tap_state_t s, logic tms);
		unique case (s)
			S_TLR:   tapNext = tms ? S_TLR   : S_RTI;
			S_RTI:   tapNext = tms ? S_SELDR : S_RTI;
			S_SELDR: tapNext = tms ? S_SELIR : S_CAPDR;
			S_CAPDR: tapNext = tms ? S_EX1DR : S_SHDR;
			S_SHDR:  tapNext = tms ? S_EX1DR : S_SHDR;
			S_EX1DR: tapNext = tms ? S_UPDR  : S_PADR;
			S_PADR:  tapNext = tms ? S_EX2DR : S_PADR;
			S_EX2DR: tapNext = tms ? S_UPDR  : S_SHDR;
			S_UPDR:  tapNext = tms ? S_SELDR : S_RTI;
			S_SELIR: tapNext = tms ? S_TLR   : S_CAPIR;
			S_CAPIR: tapNext = tms ? S_EX1IR : S_SHIR;
			S_SHIR:  tapNext = tms ? S_EX1IR : S_SHIR;
			S_EX1IR: tapNext = tms ? S_UPIR  : S_PAIR;
			S_PAIR:  tapNext = tms ? S_EX2IR : S_PAIR;
			S_EX2IR: tapNext = tms ? S_UPIR  : S_SHIR;
			S_UPIR:  tapNext = tms ? S_SELDR : S_RTI;
			default: tapNext = S_TLR;
		endcase
	endfunction

	function automatic bsi_path_t pathOf(logic [IR_W-1:0] ir);
		unique case (ir)
			IR_IDCODE:                        pathOf = PATH_ID;
			IR_EXTEST, IR_SAMPLE, IR_SAMPLEZ: pathOf = PATH_BSR;
			default:                          pathOf = PATH_BYP;
		endcase
	endfunction

	assign tapState_next = tapNext(tapState_reg, pinsSync.tms);
	assign path          = pathOf(ir_reg);

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			tapState_reg <= S_TLR;
		end else if (ce && tckRise) begin
			tapState_reg <= tapState_next;
		end
	end

	// Instruction register: capture and shift on rising TCK, update on falling TCK
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irShift_reg <= IR_CAPTURE;
			ir_reg      <= IR_RESET;
		end else if (ce) begin
			if (tapState_reg == S_TLR) begin
				ir_reg <= IR_RESET;
			end else if (tckFall && tapState_reg == S_UPIR) begin
				ir_reg <= irShift_reg;
			end
			if (tckRise && tapState_reg == S_CAPIR) begin
				irShift_reg <= IR_CAPTURE;
			end else if (tckRise && tapState_reg == S_SHIR) begin
				irShift_reg <= {pinsSync.tdi, irShift_reg[IR_W-1:1]};
			end
		end
	end

	// Data registers: capture and shift on rising TCK
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			idShift_reg  <= '0;
			bypass_reg   <= 1'b0;
			bsrShift_reg <= '0;
		end else if (ce && tckRise) begin
			if (tapState_reg == S_CAPDR) begin
				unique case (path)
					PATH_ID:  idShift_reg  <= ID_VALUE;
					PATH_BSR: bsrShift_reg <= {qPadSync, memInSync};
					PATH_BYP: bypass_reg   <= 1'b0;
				endcase
			end else if (tapState_reg == S_SHDR) begin
				unique case (path)
					PATH_ID:  idShift_reg  <= {pinsSync.tdi, idShift_reg[ID_W-1:1]};
					PATH_BSR: bsrShift_reg <= {pinsSync.tdi, bsrShift_reg[BSR_W-1:1]};
					PATH_BYP: bypass_reg   <= pinsSync.tdi;
				endcase
			end
		end
	end

	// Update latch holds preload data for a later EXTEST
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			bsrUpd_reg <= '0;
		end else if (ce && tckFall && tapState_reg == S_UPDR && path == PATH_BSR && ir_reg != IR_SAMPLEZ) begin
			bsrUpd_reg <= bsrShift_reg;
		end
	end

	// TDO changes on falling TCK so the far end samples it stable
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			tdo   <= 1'b0;
			tdoOe <= 1'b0;
		end else if (ce && tckFall) begin
			tdoOe <= (tapState_reg == S_SHDR) || (tapState_reg == S_SHIR);
			if (tapState_reg == S_SHIR) begin
				tdo <= irShift_reg[0];
			end else begin
				unique case (path)
					PATH_ID:  tdo <= idShift_reg[0];
					PATH_BSR: tdo <= bsrShift_reg[0];
					PATH_BYP: tdo <= bypass_reg;
				endcase
			end
		end
	end

	// Read-data pin drive
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			qOut <= '0;
			qOe  <= 1'b0;
		end else if (ce) begin
			if (ir_reg == IR_EXTEST) begin
				qOut <= bsrUpd_reg[BSR_W-1:IN_W];
				qOe  <= 1'b1;
			end else if (ir_reg == IR_SAMPLEZ) begin
				qOut <= coreQ;
				qOe  <= 1'b0;
			end else begin
				qOut <= coreQ;
				qOe  <= coreQOe;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_sampleZ_float;
		(ce && ir_reg == IR_SAMPLEZ) |=> !qOe;
	endproperty
	a_sampleZ_float: assert property (p_sampleZ_float) else $error("Q pins not floated in SAMPLE-Z");

	property p_extest_drive;
		(ce && ir_reg == IR_EXTEST) |=> (qOe && qOut == $past(bsrUpd_reg[BSR_W-1:IN_W]));
	endproperty
	a_extest_drive: assert property (p_extest_drive) else $error("EXTEST does not drive preload data");

	property p_reset_idcode;
		(ce && tapState_reg == S_TLR) |=> ir_reg == IR_IDCODE;
	endproperty
	a_reset_idcode: assert property (p_reset_idcode) else $error("IDCODE not selected in reset state");

	property p_id_capture;
		(ce && tckRise && tapState_reg == S_CAPDR && ir_reg == IR_IDCODE) |=> idShift_reg == ID_VALUE;
	endproperty
	a_id_capture: assert property (p_id_capture) else $error("Identification value not captured");

	property p_id_shift;
		(ce && tckFall && tapState_reg == S_SHDR && ir_reg == IR_IDCODE) |=> (tdo == $past(idShift_reg[0]) && tdoOe);
	endproperty
	a_id_shift: assert property (p_id_shift) else $error("TDO not from identification register");

	property p_bypass_shift;
		(ce && tckFall && tapState_reg == S_SHDR && pathOf(ir_reg) == PATH_BYP) |=> tdo == $past(bypass_reg);
	endproperty
	a_bypass_shift: assert property (p_bypass_shift) else $error("TDO not from bypass register");

	property p_sample_capture;
		(ce && tckRise && tapState_reg == S_CAPDR && ir_reg == IR_SAMPLE)
			|=> bsrShift_reg == {$past(qPadSync), $past(memInSync)};
	endproperty
	a_sample_capture: assert property (p_sample_capture) else $error("Pin levels not captured");

	property p_bsr_shift;
		(ce && tckFall && tapState_reg == S_SHDR && (ir_reg == IR_SAMPLE || ir_reg == IR_SAMPLEZ))
			|=> tdo == $past(bsrShift_reg[0]);
	endproperty
	a_bsr_shift: assert property (p_bsr_shift) else $error("TDO not from boundary register");

	property p_tdi_undriven;
		(ce && !tdiDriven) [*3] |-> pinsSync.tdi;
	endproperty
	a_tdi_undriven: assert property (p_tdi_undriven) else $error("Undriven TDI not read as one");

	property p_tms_undriven;
		(ce && !tmsDriven) [*3] |-> pinsSync.tms;
	endproperty
	a_tms_undriven: assert property (p_tms_undriven) else $error("Undriven TMS not read as one");
endmodule

// file: dv/bsi_tap_ctrl.sv
// Behavioural test controller that drives the boundary-scan port
`timescale 1ns/1ps
module bsi_tap_ctrl
	import bsi_pkg::*;
(
	output bsi_tap_pins_t pins,
	input  wire logic     tdo
);
	// Link clock parked low between frames
	initial begin
		pins = '0;
	end

	task automatic tick(input logic tmsV, input logic tdiV, output logic tdoV);
		pins.tms = tmsV;
		pins.tdi = tdiV;
		#160;
		pins.tck = 1'b1;
		#160;
		// Output from the last falling edge still stands here
		tdoV = tdo;
		pins.tck = 1'b0;
	endtask

	// Starts and ends in Run-Test/Idle; LSB first both ways
	task automatic scan(input logic isIr, input int n, input logic [127:0] din, output logic [127:0] dout);
		logic b;
		dout = '0;
		tick(1'b1, 1'b0, b);
		if (isIr)
			tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
		tick(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], b);
			dout[i] = b;
		end
		tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
	endtask
endmodule

// file: dv/tb.sv
// Self-checking bench for the boundary-scan instruction logic
`timescale 1ns/1ps
module tb
	import bsi_pkg::*;
;
	localparam logic [31:0] ID_VAL = 32'h0c3a_5e71;  // Arbitrary value, bit 0 set
	typedef struct {
		logic [2:0] ir;
		int         len;
		int         capW;
		logic       qOeExp;
	} bsi_row_t;
	logic          clock;
	logic          sys_rst;
	logic          tmsDriven;
	logic          tdiDriven;
	logic [72:0]   memIn;
	logic [35:0]   qPadIn;
	logic [35:0]   coreQ = 36'h0_f0f0_f0f0;
	logic [35:0]   qOut;
	logic          qOe;
	logic          tdo;
	logic          tdoOe;
	logic          b;
	logic [127:0]  d;
	logic [127:0]  m;
	logic [127:0]  capV;
	bsi_tap_pins_t pins;
	int            error_cnt;
	int            total_checks;
	localparam logic [127:0] PAT = 128'h5a5a_c3c3_0ff0_9669_a55a_3cc3_f00f_6996;
	bsi_row_t rows [8] = '{
		'{IR_EXTEST, 109, 73, 1'b1},
		'{IR_IDCODE, 32, 32, 1'b1},
		'{IR_SAMPLEZ, 109, 109, 1'b0},
		'{3'h3, 1, 1, 1'b1},
		'{IR_SAMPLE, 109, 109, 1'b1},
		'{3'h5, 1, 1, 1'b1},
		'{3'h6, 1, 1, 1'b1},
		'{IR_BYPASS, 1, 1, 1'b1}
	};

	bsi_scan #(.ID_VALUE(ID_VAL)) dut (
		.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .tapPins(pins),
		.tmsDriven(tmsDriven), .tdiDriven(tdiDriven), .memIn(memIn), .qPadIn(qPadIn),
		.coreQ(coreQ), .coreQOe(1'b1), .qOut(qOut), .qOe(qOe), .tdo(tdo), .tdoOe(tdoOe)
	);
	// Released TDO reads as the inverse so a late enable corrupts the data
	bsi_tap_ctrl ctrl (.pins(pins), .tdo(tdoOe ? tdo : ~tdo));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Memory clocks keep running during every test access
	always @(negedge clock) coreQ <= ~coreQ;

	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic final_report();
		$display("Checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#2_000_000;
		error_cnt++;
		final_report();
	end

	initial begin
		sys_rst = 1'b1;
		tmsDriven = 1'b1;
		tdiDriven = 1'b1;
		// Pins held stable across every capture
		memIn = 73'h1_2345_6789_abcd_ef01_23;
		qPadIn = 36'h9_a5c3_e17b;
		error_cnt = 0;
		total_checks = 0;
		repeat (12) @(negedge clock);
		sys_rst = 1'b0;
		repeat (4) @(negedge clock);
		ctrl.tick(1'b0, 1'b0, b);
		for (int r = 0; r < 8; r++) begin
			ctrl.scan(1'b1, 3, {125'h0, rows[r].ir}, d);
			repeat (6) @(negedge clock);
			chk("qOe", {127'h0, rows[r].qOeExp}, {127'h0, qOe});
			chk("tdoOe idle", 128'h0, {127'h0, tdoOe});
			if (rows[r].ir != IR_EXTEST) chk("qOut core", {92'h0, coreQ}, {92'h0, qOut});
			capV = rows[r].ir == IR_IDCODE ? {96'h0, ID_VAL} : rows[r].len == 1 ? '0 : {19'h0, qPadIn, memIn};
			ctrl.scan(1'b0, 128, PAT, d);
			m = (128'h1 << rows[r].capW) - 1;
			chk("capture", capV & m, d & m);
			m = ~128'h0 >> rows[r].len;
			chk("path", PAT & m, (d >> rows[r].len) & m);
		end
		// Preload the first vector, then switch to external test
		ctrl.scan(1'b1, 3, {125'h0, IR_SAMPLE}, d);
		ctrl.scan(1'b0, 109, ~PAT, d);
		ctrl.scan(1'b1, 3, {125'h0, IR_EXTEST}, d);
		repeat (6) @(negedge clock);
		chk("extest qOe", 128'h1, {127'h0, qOe});
		chk("extest qOut", {92'h0, ~PAT[108:73]}, {92'h0, qOut});
		// Undriven data input shifts in ones
		ctrl.scan(1'b1, 3, {125'h0, IR_BYPASS}, d);
		tdiDriven = 1'b0;
		ctrl.scan(1'b0, 128, '0, d);
		tdiDriven = 1'b1;
		chk("undriven tdi", {127'h0, 1'b0} | ~128'h1, d);
		// Undriven mode select walks into Test-Logic-Reset
		tmsDriven = 1'b0;
		repeat (5) ctrl.tick(1'b0, 1'b0, b);
		tmsDriven = 1'b1;
		ctrl.tick(1'b0, 1'b0, b);
		ctrl.scan(1'b0, 32, '0, d);
		chk("id after tlr", {96'h0, ID_VAL}, d);
		// Reset in mid-run restores the identification instruction
		ctrl.scan(1'b1, 3, {125'h0, IR_BYPASS}, d);
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		repeat (4) @(negedge clock);
		ctrl.tick(1'b0, 1'b0, b);
		ctrl.scan(1'b0, 32, '0, d);
		chk("id after reset", {96'h0, ID_VAL}, d);
		final_report();
	end
endmodule
